// *** inc/abac_regs.svh ***
`ifndef ABAC_REGS_SVH
`define ABAC_REGS_SVH
//--------------------------------------------------------------
// Operation
//--------------------------------------------------------------
// Operation
// - no accumulate, no burst: keep latest result
// - accumulate on: sum results; software zeroes sum
// - accumulate enable is write-only, reads zero
// - justify field shifts or left-justifies reads
// - burst runs 1,4,8,16,32,64 conversions
// - software keeps repeat count zero outside burst
// - power-up register bits 7:4 read zero
// - no burst: power follows converter enable
// - burst, enable set: stay powered, start at once
// - burst, enable clear: sleep, wait power-up delay
// - power-up delay is (code+1) x 400 ns
// - track delay is (64-code) x 50 ns
// - delayed tracking adds three converter clocks
// - no track delay before first burst conversion
// - track register bits 7:6 read zero
// - result byte write loads accumulator byte
// - burst uses 20 MHz oscillator as converter source

//--------------------------------------------------------------
// register map
//--------------------------------------------------------------
`define ABAC_PAGE_MAIN     4'h0
`define ABAC_PAGE_BURST    4'hf
`define ABAC_ADDR_ACC_CFG  8'hba
`define ABAC_ADDR_PWR      8'hba
`define ABAC_ADDR_TRK      8'hbd
`define ABAC_ADDR_RES_LO   8'hbd
`define ABAC_ADDR_RES_HI   8'hbe
`define ABAC_ACC_CFG_RST   8'h00
`define ABAC_PWR_RST       4'h0
`define ABAC_TRK_RST       6'h16
`define ABAC_ACC_AE_BIT    6
`define ABAC_SJST_LSB      3
`define ABAC_RPT_LSB       0
`define ABAC_SJST_LEFT     3'h4
`define ABAC_LEFT_SHIFT    6

//--------------------------------------------------------------
// timing
//--------------------------------------------------------------
`define ABAC_CLK_MHZ       200
`define ABAC_PWR_UNIT_NS   400
`define ABAC_TRK_UNIT_NS   50
`define ABAC_OSC_MHZ       20
`define ABAC_PWR_UNIT_CYC  ((`ABAC_PWR_UNIT_NS * `ABAC_CLK_MHZ) / 1000)
`define ABAC_TRK_UNIT_CYC  ((`ABAC_TRK_UNIT_NS * `ABAC_CLK_MHZ) / 1000)
`define ABAC_OSC_DIV       (`ABAC_CLK_MHZ / `ABAC_OSC_MHZ)
`define ABAC_TRK_BASE      64
`define ABAC_XTRK_TICKS    3

//--------------------------------------------------------------
// controller registers on ahb
//--------------------------------------------------------------
`define ABAC_AHB_CMD       8'h00
`define ABAC_AHB_STAT      8'h04
`define ABAC_CMD_WR_BIT    24
`define ABAC_CMD_ADDR_LSB  0
`define ABAC_CMD_PAGE_LSB  8
`define ABAC_CMD_DATA_LSB  16
`endif

// *** inc/abac_pkg.sv ***
package abac_pkg;
   typedef enum logic [4:0] {
      ABAC_S_IDLE  = 5'b00001,
      ABAC_S_PWRUP = 5'b00010,
      ABAC_S_TRACK = 5'b00100,
      ABAC_S_XTRK  = 5'b01000,
      ABAC_S_CONV  = 5'b10000
   } abac_state_t;

   typedef enum logic [2:0] {
      ABAC_H_IDLE  = 3'b001,
      ABAC_H_STRB  = 3'b010,
      ABAC_H_CAPT  = 3'b100
   } abac_hstate_t;

   typedef logic [7:0]  abac_byte_t;
   typedef logic [15:0] abac_acc_t;
endpackage

// *** inc/abac_if.sv ***
interface abac_if;
   logic [3:0] sfr_page;
   logic [7:0] sfr_addr;
   logic       sfr_wr;
   logic       sfr_rd;
   logic [7:0] sfr_wdata;
   logic [7:0] sfr_rdata;

   modport dev (input sfr_page, input sfr_addr, input sfr_wr, input sfr_rd, input sfr_wdata, output sfr_rdata);
   modport ctl (output sfr_page, output sfr_addr, output sfr_wr, output sfr_rd, output sfr_wdata, input sfr_rdata);
endinterface

// *** hdl/abac_dev.sv ***
// Our own choice: the AHB-Lite register port.
`include "abac_regs.svh"

module abac_dev #(
   parameter int RES_W   = 10,
   parameter int CNT_W   = 16
) (
   input  wire logic              hclk,
   input  wire logic              hresetn,
   abac_if.dev                    sfr,
   input  wire logic              burst_mode_enable,
   input  wire logic              converter_enable,
   input  wire logic              delayed_track_select,
   input  wire logic              conv_soc,
   input  wire logic              sar_tick,
   input  wire logic              core_done,
   input  wire logic [RES_W-1:0]  core_result,
   output logic                   core_start,
   output logic                   core_power,
   output logic                   core_osc_sel,
   output logic                   core_clk_tick
);
   import abac_pkg::*;

   //--------------------------------------------------------------
   // parameter checks
   //--------------------------------------------------------------
   if (RES_W != 10) begin : g_bad_res
      $error("result width must be 10");
   end
   // the delay function works through an int, so wider counters cannot be served
   if (CNT_W < 11 || CNT_W > 32) begin : g_bad_cnt
      $error("delay counter width out of range");
   end

   // delay in clock cycles minus one, for loading a down-counter
   function automatic logic [CNT_W-1:0] f_delay(input logic [6:0] units, input int unit_cyc);
      int prod;
      prod = int'(units) * unit_cyc - 1;
      return prod[CNT_W-1:0];
   endfunction

   // repeat field to conversion count; reserved codes run one
   function automatic logic [6:0] f_repeat(input logic [2:0] code);
      case (code)
         3'h1:    return 7'h04;
         3'h2:    return 7'h08;
         3'h3:    return 7'h10;
         3'h4:    return 7'h20;
         3'h5:    return 7'h40;
         default: return 7'h01;
      endcase
   endfunction

   //--------------------------------------------------------------
   // registers
   //--------------------------------------------------------------
   logic              acc_en_q;
   logic [2:0]        sjst_q;
   logic [2:0]        rpt_q;
   logic [3:0]        pwr_q;
   logic [5:0]        trk_q;
   abac_acc_t         acc_q;
   abac_acc_t         acc_d;
   abac_byte_t        rdata_q;
   abac_state_t       st_q;
   abac_state_t       st_d;
   logic [CNT_W-1:0]  cnt_q;
   logic [CNT_W-1:0]  cnt_d;
   logic [6:0]        done_q;
   logic [6:0]        done_d;
   logic [1:0]        xtr_q;
   logic [1:0]        xtr_d;
   logic              start_q;
   logic              start_d;
   logic [3:0]        osc_q;
   logic              tick_q;

   // address decode
   wire pg_main   = (sfr.sfr_page == `ABAC_PAGE_MAIN);
   wire pg_burst  = (sfr.sfr_page == `ABAC_PAGE_BURST);
   wire hit_cfg   = pg_main  && (sfr.sfr_addr == `ABAC_ADDR_ACC_CFG);
   wire hit_lo    = pg_main  && (sfr.sfr_addr == `ABAC_ADDR_RES_LO);
   wire hit_hi    = pg_main  && (sfr.sfr_addr == `ABAC_ADDR_RES_HI);
   wire hit_pwr   = pg_burst && (sfr.sfr_addr == `ABAC_ADDR_PWR);
   wire hit_trk   = pg_burst && (sfr.sfr_addr == `ABAC_ADDR_TRK);

   // justified view of the accumulator; reserved codes read unshifted
   wire       sjst_left = (sjst_q == `ABAC_SJST_LEFT);
   wire       sjst_rsv  = sjst_q[2] && !sjst_left;
   wire [1:0] rshift    = sjst_rsv ? 2'h0 : sjst_q[1:0];
   wire abac_acc_t fmt  = sjst_left ? (acc_q << `ABAC_LEFT_SHIFT) : (acc_q >> rshift);

   // read mux; accumulate enable and reserved bits read as zero
   wire abac_byte_t cfg_rd = {2'h0, sjst_q, rpt_q};
   wire abac_byte_t rd_mux = hit_cfg ? cfg_rd :
                             hit_lo  ? fmt[7:0] :
                             hit_hi  ? fmt[15:8] :
                             hit_pwr ? {4'h0, pwr_q} :
                             hit_trk ? {2'h0, trk_q} :
                             8'h00;
   assign sfr.sfr_rdata = rdata_q;

   // config write and read capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         acc_en_q <= 1'(`ABAC_ACC_CFG_RST >> `ABAC_ACC_AE_BIT);
         sjst_q   <= 3'(`ABAC_ACC_CFG_RST >> `ABAC_SJST_LSB);
         rpt_q    <= 3'(`ABAC_ACC_CFG_RST >> `ABAC_RPT_LSB);
         pwr_q    <= `ABAC_PWR_RST;
         trk_q    <= `ABAC_TRK_RST;
         rdata_q  <= 8'h00;
      end else begin
         if (sfr.sfr_rd) begin
            rdata_q <= rd_mux;
         end
         if (sfr.sfr_wr && hit_cfg) begin
            acc_en_q <= sfr.sfr_wdata[`ABAC_ACC_AE_BIT];
            sjst_q   <= sfr.sfr_wdata[`ABAC_SJST_LSB +: 3];
            rpt_q    <= sfr.sfr_wdata[`ABAC_RPT_LSB +: 3];
         end
         if (sfr.sfr_wr && hit_pwr) begin
            pwr_q <= sfr.sfr_wdata[3:0];  // upper bits dropped
         end
         if (sfr.sfr_wr && hit_trk) begin
            trk_q <= sfr.sfr_wdata[5:0];
         end
      end
   end

   //--------------------------------------------------------------
   // sequencer
   //--------------------------------------------------------------
   wire [6:0] n_total  = burst_mode_enable ? f_repeat(rpt_q) : 7'h01;
   wire [6:0] n_next   = done_q + 7'h01;
   wire       more     = burst_mode_enable && (n_next < n_total);
   wire [6:0] pwr_u    = {3'h0, pwr_q} + 7'h01;
   wire [6:0] trk_u    = 7'(`ABAC_TRK_BASE) - {1'b0, trk_q};
   wire       res_add  = core_done && (st_q == ABAC_S_CONV);
   wire abac_acc_t res_ext = {{(16 - RES_W){1'b0}}, core_result};

   // next state; first conversion goes to power-up wait, tracking extension or convert, with no track delay
   always_comb begin
      st_d    = st_q;
      cnt_d   = cnt_q;
      done_d  = done_q;
      xtr_d   = xtr_q;
      start_d = 1'b0;
      case (st_q)
         ABAC_S_IDLE: begin
            if (conv_soc && (converter_enable || burst_mode_enable)) begin
               done_d = 7'h00;
               xtr_d  = 2'h0;
               if (burst_mode_enable && !converter_enable) begin
                  st_d  = ABAC_S_PWRUP;
                  cnt_d = f_delay(pwr_u, `ABAC_PWR_UNIT_CYC);
               end else if (delayed_track_select) begin
                  st_d = ABAC_S_XTRK;
               end else begin
                  st_d    = ABAC_S_CONV;
                  start_d = 1'b1;
               end
            end
         end
         ABAC_S_PWRUP, ABAC_S_TRACK: begin
            if (cnt_q == '0) begin
               xtr_d = 2'h0;
               if (delayed_track_select) begin
                  st_d = ABAC_S_XTRK;
               end else begin
                  st_d    = ABAC_S_CONV;
                  start_d = 1'b1;
               end
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         ABAC_S_XTRK: begin
            if (sar_tick) begin
               xtr_d = xtr_q + 2'h1;
               if (xtr_q == 2'(`ABAC_XTRK_TICKS - 1)) begin
                  st_d    = ABAC_S_CONV;
                  start_d = 1'b1;
               end
            end
         end
         ABAC_S_CONV: begin
            if (core_done) begin
               done_d = n_next;
               if (more) begin
                  st_d  = ABAC_S_TRACK;  // only between conversions
                  cnt_d = f_delay(trk_u, `ABAC_TRK_UNIT_CYC);
               end else begin
                  st_d = ABAC_S_IDLE;
               end
            end
         end
         default: st_d = ABAC_S_IDLE;
      endcase
   end

   // accumulator; a software byte write wins over a result in the same cycle for the byte it writes, the other byte takes the result
   always_comb begin
      acc_d = acc_q;
      if (res_add) begin
         if (burst_mode_enable || acc_en_q) begin
            acc_d = acc_q + res_ext;
         end else begin
            acc_d = res_ext;
         end
      end
      if (sfr.sfr_wr && hit_lo) begin
         acc_d[7:0] = sfr.sfr_wdata;
      end
      if (sfr.sfr_wr && hit_hi) begin
         acc_d[15:8] = sfr.sfr_wdata;
      end
   end

   // sequencer state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q    <= ABAC_S_IDLE;
         cnt_q   <= '0;
         done_q  <= 7'h00;
         xtr_q   <= 2'h0;
         start_q <= 1'b0;
         acc_q   <= 16'h0000;
      end else begin
         st_q    <= st_d;
         cnt_q   <= cnt_d;
         done_q  <= done_d;
         xtr_q   <= xtr_d;
         start_q <= start_d;
         acc_q   <= acc_d;
      end
   end

   //--------------------------------------------------------------
   // converter clock source and power
   //--------------------------------------------------------------
   // oscillator stand-in: a divider enable, since only one clock exists
   wire osc_wrap = (osc_q == 4'(`ABAC_OSC_DIV - 1));
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         osc_q  <= 4'h0;
         tick_q <= 1'b0;
      end else begin
         osc_q  <= osc_wrap ? 4'h0 : osc_q + 4'h1;
         tick_q <= burst_mode_enable ? osc_wrap : 1'b1;
      end
   end

   // power stays up while a burst is past its power-up wait, even with enable clear
   wire busy = (st_q != ABAC_S_IDLE) && (st_q != ABAC_S_PWRUP);
   assign core_power    = burst_mode_enable ? (converter_enable || busy) : converter_enable;
   assign core_osc_sel  = burst_mode_enable;
   assign core_clk_tick = tick_q;
   assign core_start    = start_q;
endmodule

// *** hdl/abac_host.sv ***
`include "abac_regs.svh"

module abac_host (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   abac_if.ctl              sfr
);
   import abac_pkg::*;

   //--------------------------------------------------------------
   // ahb slave
   //--------------------------------------------------------------
   logic              dwr_q;
   logic [7:0]        daddr_q;
   logic [31:0]       hrdata_q;
   abac_hstate_t      st_q;
   logic [3:0]        page_q;
   logic [7:0]        addr_q;
   abac_byte_t        wdata_q;
   logic              iswr_q;
   abac_byte_t        rbyte_q;

   wire        busy     = (st_q != ABAC_H_IDLE);
   wire        a_phase  = hsel && hready && htrans[1];
   wire [31:0] stat_val = {16'h0000, rbyte_q, 7'h00, busy};
   wire [31:0] rd_mux   = (haddr[7:0] == `ABAC_AHB_STAT) ? stat_val : 32'h0000_0000;
   // commands arriving while busy are dropped; software polls busy first
   wire        cmd_go   = dwr_q && (daddr_q == `ABAC_AHB_CMD) && !busy;

   // zero-wait slave; unmapped reads give zero, writes vanish
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dwr_q    <= 1'b0;
         daddr_q  <= 8'h00;
         hrdata_q <= 32'h0000_0000;
      end else begin
         dwr_q <= a_phase && hwrite;
         if (a_phase) begin
            daddr_q <= haddr[7:0];
         end
         if (a_phase && !hwrite) begin
            hrdata_q <= rd_mux;
         end
      end
   end

   //--------------------------------------------------------------
   // sfr access sequencer
   //--------------------------------------------------------------
   // strobe one cycle; read data appears the cycle after
   assign sfr.sfr_page  = page_q;
   assign sfr.sfr_addr  = addr_q;
   assign sfr.sfr_wdata = wdata_q;
   assign sfr.sfr_wr    = (st_q == ABAC_H_STRB) && iswr_q;
   assign sfr.sfr_rd    = (st_q == ABAC_H_STRB) && !iswr_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q    <= ABAC_H_IDLE;
         page_q  <= 4'h0;
         addr_q  <= 8'h00;
         wdata_q <= 8'h00;
         iswr_q  <= 1'b0;
         rbyte_q <= 8'h00;
      end else begin
         case (st_q)
            ABAC_H_IDLE: begin
               if (cmd_go) begin
                  addr_q  <= hwdata[`ABAC_CMD_ADDR_LSB +: 8];
                  page_q  <= hwdata[`ABAC_CMD_PAGE_LSB +: 4];
                  wdata_q <= hwdata[`ABAC_CMD_DATA_LSB +: 8];
                  iswr_q  <= hwdata[`ABAC_CMD_WR_BIT];
                  st_q    <= ABAC_H_STRB;
               end
            end
            ABAC_H_STRB: st_q <= iswr_q ? ABAC_H_IDLE : ABAC_H_CAPT;
            ABAC_H_CAPT: begin
               rbyte_q <= sfr.sfr_rdata;  // device byte stands one cycle after the strobe
               st_q    <= ABAC_H_IDLE;
            end
            default: st_q <= ABAC_H_IDLE;
         endcase
      end
   end
   // repeat field and reserved bits are written as given by software
endmodule

// *** sim/abac_props.sv ***
//---------------------------------------
// sfr link and converter pin checks
//---------------------------------------
module abac_props (
   input wire logic       hclk,
   input wire logic       hresetn,
   input wire logic [3:0] sfr_page,
   input wire logic [7:0] sfr_addr,
   input wire logic       sfr_rd,
   input wire logic [7:0] sfr_rdata,
   input wire logic       conv_soc,
   input wire logic       burst_mode_enable,
   input wire logic       converter_enable,
   input wire logic       delayed_track_select,
   input wire logic       core_start,
   input wire logic       core_power,
   input wire logic       core_osc_sel,
   input wire logic       core_clk_tick
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // read strobe on one page and address
   sequence s_rd(logic [3:0] p, logic [7:0] a);
      sfr_rd && sfr_page == p && sfr_addr == a;
   endsequence
   // start with the converter already powered
   sequence s_soc_now;
      conv_soc && converter_enable && !delayed_track_select;
   endsequence
   // start that must wait before converting
   sequence s_soc_wait;
      conv_soc && (delayed_track_select || burst_mode_enable && !converter_enable);
   endsequence

   a_cfg_upper_zero:
   assert property (s_rd(4'h0, 8'hba) |=> sfr_rdata[7:6] == 2'b00)
      else $error("config read upper bits not zero");
   a_pwr_upper_zero:
   assert property (s_rd(4'hf, 8'hba) |=> sfr_rdata[7:4] == 4'h0)
      else $error("power-up read upper bits not zero");
   a_trk_upper_zero:
   assert property (s_rd(4'hf, 8'hbd) |=> sfr_rdata[7:6] == 2'b00)
      else $error("track read upper bits not zero");
   a_osc_src_burst:
   assert property (core_osc_sel == burst_mode_enable)
      else $error("converter source not following burst");
   a_power_follows_en:
   assert property (!burst_mode_enable |-> core_power == converter_enable)
      else $error("power not following enable");
   a_power_burst_held:
   assert property (burst_mode_enable && converter_enable |-> core_power)
      else $error("powered burst dropped power");
   a_start_at_once:
   assert property (s_soc_now |=> core_start)
      else $error("start not launched at once");
   a_start_held:
   assert property (s_soc_wait |=> !core_start [*8])
      else $error("start launched without its wait");
   a_pwrup_dark:
   assert property (conv_soc && burst_mode_enable && !converter_enable |=> !core_power [*8])
      else $error("powered during power-up wait");
   a_start_single:
   assert property (core_start |=> !core_start)
      else $error("start longer than one cycle");
   a_tick_div:
   assert property (core_clk_tick && burst_mode_enable && $past(burst_mode_enable, 2)
                    |=> (!core_clk_tick || !burst_mode_enable) [*8])
      else $error("burst converter tick too fast");
endmodule

// *** sim/tb_adc_burst_accumulator_ctrl.sv ***
//---------------------------------------
// bench for the burst accumulator control
//---------------------------------------
module tb_adc_burst_accumulator_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   import abac_pkg::*;
   logic        hclk, hresetn = 1'b0, hwrite = 1'b0, hreadyout, hresp;
   logic [1:0]  htrans = 2'b00;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic        burst_mode_enable = 1'b0, converter_enable = 1'b0, delayed_track_select = 1'b0;
   logic        conv_soc = 1'b0, sar_tick = 1'b0, core_done = 1'b0;
   logic        core_start, core_power, core_osc_sel, core_clk_tick;
   logic [9:0]  core_result = 10'h0, r;
   logic [15:0] sum, last_res, v;
   int          error_cnt, comparisons, cyc, soc_cyc, done_cyc, nstart, ndone, ntick;
   int          gap_first, tick_first, gap_exp, cdly, trk, pc, n;
   abac_if      sfr_if ();

   abac_host u_abac_host (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .sfr(sfr_if.ctl));
   abac_dev u_abac_dev (.hclk, .hresetn, .sfr(sfr_if.dev), .burst_mode_enable, .converter_enable,
      .delayed_track_select, .conv_soc, .sar_tick, .core_done, .core_result, .core_start, .core_power,
      .core_osc_sel, .core_clk_tick);
   abac_props u_abac_props (.hclk, .hresetn, .sfr_page(sfr_if.sfr_page), .sfr_addr(sfr_if.sfr_addr),
      .sfr_rd(sfr_if.sfr_rd), .sfr_rdata(sfr_if.sfr_rdata), .conv_soc, .burst_mode_enable, .converter_enable,
      .delayed_track_select, .core_start, .core_power, .core_osc_sel, .core_clk_tick);

   // 200 mhz clock
   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end

   //---------------------------------------
   // helpers
   //---------------------------------------
   task automatic stop_test;
      $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask

   // pipeline slack of two cycles on long waits
   function automatic int near(input int e, input int g);
      return (g >= e && g <= e + 2) ? e : g;
   endfunction

   function automatic logic [15:0] just(input logic [15:0] a, input logic [2:0] j);
      if (j == 3'h4)
         return a << 6;
      return (j < 3'h4) ? a >> j : a;
   endfunction

   // one single word transfer, waits on the slave's ready
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'b10;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   // command word, then poll busy; read byte lands in rd[15:8]
   task automatic sfr(input logic wr, input logic [3:0] pg, input logic [7:0] a, input logic [7:0] d);
      ahb(1'b1, 32'h0, {7'h0, wr, d, 4'h0, pg, a});
      do ahb(1'b0, 32'h4, 32'h0); while (rd[0] !== 1'b0);
   endtask

   task automatic rchk(input logic [3:0] pg, input logic [7:0] a, input logic [7:0] e);
      sfr(1'b0, pg, a, 8'h00);
      check($sformatf("sfr %h:%h", pg, a), {24'h0, e}, {24'h0, rd[15:8]});
   endtask

   task automatic rres(input logic [15:0] e);
      rchk(4'h0, 8'hbd, e[7:0]);
      rchk(4'h0, 8'hbe, e[15:8]);
   endtask

   task automatic clr;
      sfr(1'b1, 4'h0, 8'hbe, 8'h00);
      sfr(1'b1, 4'h0, 8'hbd, 8'h00);
      sum = 16'h0;
   endtask

   // settle long enough to catch a runaway burst
   task automatic go(input int cnt);
      ndone = 0;
      nstart = 0;
      conv_soc <= 1'b1;
      @(posedge hclk);
      conv_soc <= 1'b0;
      while (ndone < cnt) @(posedge hclk);
      repeat (700) @(posedge hclk);
   endtask

   // converter core stand-in, tick source, timing monitor, timeout
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      sar_tick <= (cyc % 4 == 0);
      core_done <= 1'b0;
      if (conv_soc === 1'b1)
         soc_cyc = cyc;
      if (conv_soc === 1'b1)
         ntick = 0;
      else if (sar_tick === 1'b1)
         ntick++;
      if (core_done === 1'b1) begin
         done_cyc = cyc;
         ndone++;
      end
      if (core_start === 1'b1) begin
         if (nstart == 0) begin
            gap_first = cyc - soc_cyc;
            tick_first = ntick;
         end else if (burst_mode_enable === 1'b1)
            check("track gap", gap_exp, near(gap_exp, cyc - done_cyc));
         nstart++;
         cdly = 2 + $urandom_range(5);
      end else if (cdly > 0) begin
         cdly--;
         if (cdly == 0) begin
            r = 10'($urandom);
            core_done <= 1'b1;
            core_result <= r;
            sum = sum + {6'h0, r};
            last_res = {6'h0, r};
         end
      end
      if (cyc == 60000) begin
         error_cnt++;
         stop_test();
      end
   end

   //---------------------------------------
   // main sequence
   //---------------------------------------
   initial begin
      void'($urandom(32'hb3d7));
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      // reset values, write-only and unmapped places
      rchk(4'h0, 8'hba, 8'h00);
      rchk(4'hf, 8'hbd, 8'h16);
      sfr(1'b1, 4'hf, 8'hba, 8'h7f);
      rchk(4'hf, 8'hba, 8'h0f);
      sfr(1'b1, 4'hf, 8'hbd, 8'hff);
      rchk(4'hf, 8'hbd, 8'h3f);
      sfr(1'b1, 4'h0, 8'hba, 8'h60);
      rchk(4'h0, 8'hba, 8'h20);
      rchk(4'h0, 8'h55, 8'h00);
      ahb(1'b0, 32'h8, 32'h0);
      check("ahb unmapped", 32'h0, rd);
      check("ahb resp", 32'h0, {31'h0, hresp});
      // every justify code over a random accumulator
      for (int j = 0; j < 8; j++) begin
         v = 16'($urandom);
         sfr(1'b1, 4'h0, 8'hbe, v[15:8]);
         sfr(1'b1, 4'h0, 8'hbd, v[7:0]);
         sfr(1'b1, 4'h0, 8'hba, {2'b00, 3'(j), 3'b000});
         rres(just(v, 3'(j)));
      end
      // single conversions: latest, then summed, then delayed tracking
      sfr(1'b1, 4'h0, 8'hba, 8'h00);
      converter_enable <= 1'b1;
      go(1);
      go(1);
      rres(last_res);
      clr();
      sfr(1'b1, 4'h0, 8'hba, 8'h40);
      repeat (3) go(1);
      rres(sum);
      delayed_track_select <= 1'b1;
      go(1);
      check("track ticks", 32'd3, tick_first);
      delayed_track_select <= 1'b0;
      // powered burst over repeat codes 0 to 5
      burst_mode_enable <= 1'b1;
      trk = $urandom_range(63, 48);
      gap_exp = (64 - trk) * 10;
      sfr(1'b1, 4'hf, 8'hbd, 8'(trk));
      for (int k = 0; k < 6; k++) begin
         clr();
         sfr(1'b1, 4'h0, 8'hba, 8'(k));
         n = (k == 0) ? 1 : 2 << k;
         go(n);
         check("burst count", n, nstart);
         check("first start", 32'd1, gap_first);
         rres(sum);
      end
      check("burst power", 32'd1, {31'h0, core_power});
      check("osc source", 32'd1, {31'h0, core_osc_sel});
      // unpowered burst waits its power-up time
      converter_enable <= 1'b0;
      sfr(1'b1, 4'h0, 8'hba, 8'h00);
      for (int k = 0; k < 2; k++) begin
         pc = k ? $urandom_range(14) : 15;
         sfr(1'b1, 4'hf, 8'hba, 8'(pc));
         go(1);
         check("powerup wait", (pc + 1) * 80, near((pc + 1) * 80, gap_first));
         check("sleep power", 32'd0, {31'h0, core_power});
      end
      // plain mode power follows the enable
      burst_mode_enable <= 1'b0;
      repeat (4) begin
         converter_enable <= 1'($urandom);
         repeat (5) @(posedge hclk);
         check("plain power", {31'h0, converter_enable}, {31'h0, core_power});
         check("plain osc", 32'd0, {31'h0, core_osc_sel});
         check("plain tick", 32'd1, {31'h0, core_clk_tick});
      end
      stop_test();
   end
endmodule
